// [verilog/afe_route_pkg.sv]
// Shared constants and types for the front-end input routing block
package afe_route_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [13:0] MUX_BASE_IDX = 14'h2100;
    localparam int          MUX_REG_NUM  = 6;
    localparam logic [13:0] MODE_IDX     = 14'h210c;
    localparam logic [13:0] PREAMP_IDX   = 14'h2704;
    localparam logic [13:0] REMOTE_IDX   = 14'h2709;
    localparam logic [13:0] STATUS_IDX   = 14'h2710;
    // Field positions
    localparam int COUNT_LSB  = 4;
    localparam int DIFF_LSB   = 4;
    localparam int PREAMP_BIT = 5;
    localparam int REMOTE_LSB = 3;
    // Reset values
    localparam logic [7:0] MUX_RESET    = 8'h00;
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] PREAMP_RESET = 8'h00;
    localparam logic [7:0] REMOTE_RESET = 8'h00;
    // Frame and input limits
    localparam logic [3:0] MAX_SLOTS = 4'hb;
    localparam logic [3:0] MAX_INPUT = 4'ha;
    localparam int NUM_PAIRS   = 4;
    localparam int NUM_REMOTE  = 3;
    localparam int FIR_LEN_DEF = 288;
    // Compute-engine RAM write port layout
    localparam int SAMPLE_W = 24;
    localparam int CE_ADDR_W = 5;
    localparam logic [4:0] LOCAL_BASE  = 5'h00;
    localparam logic [4:0] REMOTE_BASE = 5'h10;

    typedef struct packed {
        logic                en;
        logic [4:0]          addr;
        logic [SAMPLE_W-1:0] data;
    } ce_write_type;

    typedef struct packed {
        logic                valid;
        logic [SAMPLE_W-1:0] data;
    } remote_sample_type;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN  = 2'b10
    } seq_state_type;
endpackage

// [verilog/boxcar_decimator.sv]
// Boxcar FIR decimator for the single local converter bit stream
`timescale 1ns/1ps
module boxcar_decimator #(
    parameter int LEN = afe_route_pkg::FIR_LEN_DEF,
    parameter int W   = afe_route_pkg::SAMPLE_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         restart,
    input  wire logic         bit_in,
    output logic              sample_valid,
    output logic [W-1:0]      sample
);
    localparam int CW = $clog2(LEN);
    localparam logic [CW-1:0] LAST = CW'(LEN - 1);

    generate
        if (LEN < 2 || (2 ** W) <= LEN) begin : g_bad_len
            $error("decimator length does not fit the sample width");
        end
    endgenerate

    logic [CW-1:0] count_reg;
    logic [W-1:0]  acc_reg;

    // Sum LEN bits then dump; restart realigns to a new slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg    <= '0;
            acc_reg      <= '0;
            sample       <= '0;
            sample_valid <= 1'b0;
        end else if (restart) begin
            count_reg    <= '0;
            acc_reg      <= '0;
            sample_valid <= 1'b0;
        end else if (count_reg == LAST) begin
            count_reg    <= '0;
            acc_reg      <= '0;
            sample       <= acc_reg + W'(bit_in);
            sample_valid <= 1'b1;
        end else begin
            count_reg    <= count_reg + CW'(1);
            acc_reg      <= acc_reg + W'(bit_in);
            sample_valid <= 1'b0;
        end
    end

    a_decim_period: assert property (@(posedge pclk) disable iff (!presetn)
        sample_valid |-> $past(count_reg) == LAST)
        else $error("sample out of decimation period");
endmodule

// [verilog/frame_sequencer.sv]
// Multiplexer frame sequencer: walks slots from zero to one below the slot count, with the count capped at MAX_SLOTS
`timescale 1ns/1ps
module frame_sequencer (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [3:0]   slot_count,
    input  wire logic         sample_valid,
    output logic [3:0]        slot,
    output logic              frame_start,
    output logic              running
);
    afe_route_pkg::seq_state_type state_reg;
    logic [3:0] len_reg;
    logic [3:0] len_next;
    logic       last_slot;

    // Counts above the slot limit (MAX_SLOTS) are served as a full frame
    assign len_next = (slot_count > afe_route_pkg::MAX_SLOTS) ?
                      afe_route_pkg::MAX_SLOTS : slot_count;
    assign last_slot = (slot == len_reg - 4'h1);
    assign running = (state_reg == afe_route_pkg::SEQ_RUN);

    // A zero count parks the sequencer at the frame boundary
    always_comb begin
        unique case (state_reg)
            afe_route_pkg::SEQ_IDLE:
                frame_start = (slot_count != 4'h0);
            afe_route_pkg::SEQ_RUN:
                frame_start = sample_valid && last_slot &&
                              (slot_count != 4'h0);
            default:
                frame_start = 1'b0;
        endcase
    end

    // Slot advance, one step per converted sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= afe_route_pkg::SEQ_IDLE;
            slot      <= 4'h0;
            len_reg   <= 4'h0;
        end else if (frame_start) begin
            state_reg <= afe_route_pkg::SEQ_RUN;
            slot      <= 4'h0;
            len_reg   <= len_next;
        end else if (running && sample_valid) begin
            if (last_slot) begin
                state_reg <= afe_route_pkg::SEQ_IDLE;
                slot      <= 4'h0;
            end else begin
                slot      <= slot + 4'h1;
            end
        end
    end

    a_frame_from_zero: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start |=> slot == 4'h0 && running)
        else $error("frame did not begin at slot zero");
    a_slot_advance: assert property (@(posedge pclk) disable iff (!presetn)
        running && sample_valid && !last_slot |=> slot == $past(slot) + 4'h1)
        else $error("slot did not advance by one");
    a_frame_length: assert property (@(posedge pclk) disable iff (!presetn)
        running |-> slot < len_reg && len_reg <= 4'hb)
        else $error("slot beyond frame length");
endmodule

// [verilog/afe_input_router.sv]
// Front-end input routing: config registers, slot muxing, RAM writes
`timescale 1ns/1ps
// Overview of operation
// - Local inputs share one converter through mux
// - Decimate converter bits, store samples in RAM
// - Remote pair samples bypass mux into RAM
// - Slot select fields set sampling order
// - Current inputs single-ended or four differential pairs
// - First pair differential when its bit set
// - Preamp bit selects gain eight, else one
// - Remote bits turn pairs two-four remote
// - Cleared remote bit keeps pair local analog
// - First pair never remote
// - Link carries samples, control and power
// - No remotes: every channel through the mux
// - Frame starts slot zero, runs slot count
// - Eleven inputs single-ended, seven differential
module afe_input_router #(
    parameter int FIR_LEN = afe_route_pkg::FIR_LEN_DEF
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [15:0]                      paddr,
    input  wire logic [31:0]                      pwdata,
    output logic [31:0]                           prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             modulator_bit,
    input  afe_route_pkg::remote_sample_type [2:0] remote_sample,
    output afe_route_pkg::ce_write_type           ce_write,
    output logic [3:0]                            slot_input_select,
    output logic [3:0]                            pair_differential,
    output logic                                  preamp_gain8,
    output logic [2:0]                            remote_pair_enable
);
    localparam int NR = afe_route_pkg::NUM_REMOTE;
    localparam int SW = afe_route_pkg::SAMPLE_W;

    // Register file as written by software
    logic [7:0] mux_reg [afe_route_pkg::MUX_REG_NUM];
    logic [7:0] mode_reg;
    logic [7:0] preamp_reg;
    logic [7:0] remote_reg;

    // Copies in force for the frame under way
    logic [7:0] act_mux_reg [afe_route_pkg::MUX_REG_NUM];
    logic [3:0] act_diff_reg;
    logic       act_preamp_reg;
    logic [2:0] act_remote_reg;

    logic       bit_meta_reg;
    logic       bit_sync_reg;
    logic [3:0] slot;
    logic       frame_start;
    logic       running;
    logic       local_valid;
    logic [SW-1:0] local_sample;
    logic [3:0] slot_now_reg;
    logic       select_error;

    logic [13:0] idx;
    logic        setup;
    logic        access;
    logic        mux_hit;
    logic [2:0]  mux_sel;
    logic        mapped;
    logic [7:0]  rd_byte;

    logic [NR-1:0]  pend_reg;
    logic [SW-1:0]  pend_data_reg [NR];
    logic [NR-1:0]  grant;

    // Converter bit arrives from the analog side: two-flop synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_meta_reg <= 1'b0;
            bit_sync_reg <= 1'b0;
        end else begin
            bit_meta_reg <= modulator_bit;
            bit_sync_reg <= bit_meta_reg;
        end
    end

    // One decimator serves all local slots in turn
    boxcar_decimator #(
        .LEN (FIR_LEN),
        .W   (SW)
    ) u_decim (
        .pclk         (pclk),
        .presetn      (presetn),
        .restart      (frame_start),
        .bit_in       (bit_sync_reg),
        .sample_valid (local_valid),
        .sample       (local_sample)
    );

    frame_sequencer u_seq (
        .pclk         (pclk),
        .presetn      (presetn),
        .slot_count   (mux_reg[0][7:afe_route_pkg::COUNT_LSB]),
        .sample_valid (local_valid),
        .slot         (slot),
        .frame_start  (frame_start),
        .running      (running)
    );

    // Bus decode; reads answer in the access phase without wait states
    assign idx     = paddr[15:2];
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign mux_hit = (idx >= afe_route_pkg::MUX_BASE_IDX) &&
                     (idx < afe_route_pkg::MUX_BASE_IDX + 14'h6);
    assign mux_sel = mux_hit ?
                     3'(idx - afe_route_pkg::MUX_BASE_IDX) : 3'h0;
    assign mapped  = mux_hit || idx == afe_route_pkg::MODE_IDX ||
                     idx == afe_route_pkg::PREAMP_IDX ||
                     idx == afe_route_pkg::REMOTE_IDX ||
                     idx == afe_route_pkg::STATUS_IDX;
    assign pready  = 1'b1;

    // Read mux; status shows the slot registered one clock late and the live sequencer state
    always_comb begin
        rd_byte = 8'h00;
        if (mux_hit) begin
            rd_byte = mux_reg[mux_sel];
        end else if (idx == afe_route_pkg::MODE_IDX) begin
            rd_byte = mode_reg;
        end else if (idx == afe_route_pkg::PREAMP_IDX) begin
            rd_byte = preamp_reg;
        end else if (idx == afe_route_pkg::REMOTE_IDX) begin
            rd_byte = remote_reg;
        end else if (idx == afe_route_pkg::STATUS_IDX) begin
            rd_byte = {2'b00, select_error, running, slot_now_reg};
        end
    end

    // Read data is captured in setup so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= {24'h00_0000, rd_byte};
            pslverr <= !mapped;
        end
    end

    // Register writes land in the access phase only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < afe_route_pkg::MUX_REG_NUM; i++) begin
                mux_reg[i] <= afe_route_pkg::MUX_RESET;
            end
            mode_reg   <= afe_route_pkg::MODE_RESET;
            preamp_reg <= afe_route_pkg::PREAMP_RESET;
            remote_reg <= afe_route_pkg::REMOTE_RESET;
        end else if (access && pwrite) begin
            if (mux_hit) begin
                mux_reg[mux_sel] <= pwdata[7:0];
            end
            if (idx == afe_route_pkg::MODE_IDX) begin
                mode_reg <= pwdata[7:0];
            end
            if (idx == afe_route_pkg::PREAMP_IDX) begin
                preamp_reg <= pwdata[7:0];
            end
            if (idx == afe_route_pkg::REMOTE_IDX) begin
                remote_reg <= pwdata[7:0];
            end
        end
    end

    // Settings take hold only at a frame boundary, never mid-frame;
    // software that holds the count at zero gets no frame meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < afe_route_pkg::MUX_REG_NUM; i++) begin
                act_mux_reg[i] <= afe_route_pkg::MUX_RESET;
            end
            act_diff_reg   <= 4'h0;
            act_preamp_reg <= 1'b0;
            act_remote_reg <= 3'h0;
        end else if (frame_start) begin
            for (int i = 0; i < afe_route_pkg::MUX_REG_NUM; i++) begin
                act_mux_reg[i] <= mux_reg[i];
            end
            act_diff_reg   <= mode_reg[afe_route_pkg::DIFF_LSB +: 4];
            act_preamp_reg <= preamp_reg[afe_route_pkg::PREAMP_BIT];
            act_remote_reg <= remote_reg[afe_route_pkg::REMOTE_LSB +: 3];
        end
    end

    // Slot s lives in byte 5 - s/2, low nibble for even s
    always_comb begin
        logic [7:0] sel_byte;
        sel_byte = act_mux_reg[3'(3'h5 - slot[3:1])];
        slot_input_select = slot[0] ? sel_byte[7:4] : sel_byte[3:0];
    end

    // Pair settings drive the analog front end; the first pair has
    // no remote bit, so it is always a local analog input
    assign pair_differential  = act_diff_reg;
    assign preamp_gain8       = act_preamp_reg;
    assign remote_pair_enable = act_remote_reg;

    // A slot naming a missing input, or the odd half of a differential
    // pair, converts anyway; the flag lets software spot the setting
    always_comb begin
        logic [1:0] pair;
        pair = slot_input_select[2:1];
        select_error = 1'b0;
        if (running && slot_input_select > afe_route_pkg::MAX_INPUT) begin
            select_error = 1'b1;
        end else if (running && !slot_input_select[3] &&
                     slot_input_select[0] && act_diff_reg[pair]) begin
            select_error = 1'b1;
        end
    end

    // Status copy of the slot in service
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_now_reg <= 4'h0;
        end else begin
            slot_now_reg <= slot;
        end
    end

    // Remote samples wait here when a local sample owns the write port.
    // New arrival beats the drain in the same cycle, so none is lost;
    // with its bit clear a pair's link samples are dropped.
    generate
        for (genvar p = 0; p < NR; p++) begin : g_remote
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend_reg[p]      <= 1'b0;
                    pend_data_reg[p] <= '0;
                end else if (remote_sample[p].valid &&
                             act_remote_reg[p]) begin
                    pend_reg[p]      <= 1'b1;
                    pend_data_reg[p] <= remote_sample[p].data;
                end else if (grant[p]) begin
                    pend_reg[p]      <= 1'b0;
                end
            end
            assign grant[p] = pend_reg[p] && !(local_valid && running) &&
                              (pend_reg & ((3'h1 << p) - 3'h1)) == 3'h0;
        end
    endgenerate

    // One RAM write port: in-frame local slot first, then lowest remote
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_write <= '0;
        end else begin
            ce_write.en <= (local_valid && running) || (grant != 3'h0);
            if (local_valid && running) begin
                ce_write.addr <= afe_route_pkg::LOCAL_BASE + 5'(slot);
                ce_write.data <= local_sample;
            end else begin
                for (int p = 0; p < NR; p++) begin
                    if (grant[p]) begin
                        ce_write.addr <= afe_route_pkg::REMOTE_BASE +
                                         5'(p + 1);
                        ce_write.data <= pend_data_reg[p];
                    end
                end
            end
        end
    end

    a_local_store: assert property (@(posedge pclk) disable iff (!presetn)
        local_valid && running |=> ce_write.en &&
        ce_write.addr == afe_route_pkg::LOCAL_BASE + 5'($past(slot)))
        else $error("local sample not stored at its slot");
    a_remote_store: assert property (@(posedge pclk) disable iff (!presetn)
        remote_sample[0].valid && act_remote_reg[0] |-> ##[1:4]
        ce_write.en && ce_write.addr == afe_route_pkg::REMOTE_BASE + 5'h1)
        else $error("remote sample not stored");
    a_remote_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !act_remote_reg[1] && !pend_reg[1] |=> !pend_reg[1])
        else $error("disabled pair accepted a sample");
    a_hold_in_frame: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_start |=> $stable(preamp_gain8) &&
        $stable(remote_pair_enable) && $stable(pair_differential))
        else $error("setting changed inside a frame");
    a_preamp_gain: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start |=> preamp_gain8 == $past(preamp_reg[5]))
        else $error("preamp gain not taken at frame start");
    a_remote_route: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start |=> remote_pair_enable == $past(remote_reg[5:3]))
        else $error("remote enables not taken");
    a_diff_first: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start |=> pair_differential[0] == $past(mode_reg[4]))
        else $error("first pair mode not taken");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        access && !mapped |-> pslverr)
        else $error("unmapped access not flagged");

    c_full_frame: cover property (@(posedge pclk) disable iff (!presetn)
        running ##1 frame_start);
    c_remote_wait: cover property (@(posedge pclk) disable iff (!presetn)
        local_valid && pend_reg != 3'h0);
    c_reg_write: cover property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && idx == afe_route_pkg::REMOTE_IDX);
endmodule

// [verification/remote_sensor_model.sv]
// Behavioural model of three isolated remote current sensors
`timescale 1ns/1ps
module remote_sensor_model (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic [2:0]                        link_power,
    input  wire logic                              stray,
    input  wire logic [2:0]                        send,
    input  wire logic [3:0]                        lag,
    input  wire logic [23:0]                       value,
    output afe_route_pkg::remote_sample_type [2:0] sample_out
);
    logic [2:0]  pend;
    logic [3:0]  wait_cnt;
    logic [23:0] last;

    // Conversion delay, then a one-cycle sample pulse per lane
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend       <= 3'h0;
            wait_cnt   <= 4'h0;
            last       <= 24'h0;
            sample_out <= '0;
        end else begin
            // Idle data inverted so a stale word never looks valid
            for (int k = 0; k < 3; k++) begin
                sample_out[k].valid <= 1'b0;
                sample_out[k].data  <= ~last;
            end
            if (send != 3'h0) begin
                pend     <= send;
                wait_cnt <= lag;
            end else if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (pend != 3'h0) begin
                // Unpowered sensor stays silent unless told to misbehave
                for (int k = 0; k < 3; k++) begin
                    if (pend[k] && (link_power[k] || stray)) begin
                        sample_out[k].valid <= 1'b1;
                        sample_out[k].data  <= value;
                    end
                end
                last <= value;
                pend <= 3'h0;
            end
        end
    end
endmodule

// [verification/sensor_input_routing_config_tb_top.sv]
// Self-checking bench for the front-end input routing block
`timescale 1ns/1ps
module sensor_input_routing_config_tb_top;
    localparam int FIR = 8;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mod_bit;
    logic        stray;
    logic [2:0]  send;
    logic [3:0]  lag;
    logic [23:0] value;
    logic [3:0]  sel;
    logic [3:0]  sel_prev;
    logic [3:0]  pdiff;
    logic        gain8;
    logic [2:0]  rmt;
    logic [3:0]  sel_q[$];
    int          err_total;
    int          checked;
    afe_route_pkg::remote_sample_type [2:0] rs;
    afe_route_pkg::ce_write_type            cw;
    afe_route_pkg::ce_write_type            loc_q[$];
    afe_route_pkg::ce_write_type            rem_q[$];

    afe_input_router #(.FIR_LEN(FIR)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .modulator_bit(mod_bit),
        .remote_sample(rs), .ce_write(cw), .slot_input_select(sel),
        .pair_differential(pdiff), .preamp_gain8(gain8),
        .remote_pair_enable(rmt)
    );

    remote_sensor_model i_far (
        .pclk(pclk), .presetn(presetn), .link_power(rmt), .stray(stray),
        .send(send), .lag(lag), .value(value), .sample_out(rs)
    );

    // Free-running 5 ns clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Alternating bits: any window of FIR bits holds FIR/2 ones
    always @(posedge pclk) mod_bit <= ~mod_bit;

    // Log RAM writes and every change of the slot select
    always @(posedge pclk) begin
        if (cw.en === 1'b1 && cw.addr < 5'h10) loc_q.push_back(cw);
        if (cw.en === 1'b1 && cw.addr >= 5'h10) rem_q.push_back(cw);
        if (sel !== sel_prev) sel_q.push_back(sel);
        sel_prev = sel;
    end

    task automatic close_out;
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // A wait ran out of its bound
    task automatic stall;
        cmp(32'h0, 32'h1);
        close_out();
    endtask

    // One APB transfer, after an idle edge
    task automatic apb(input logic wr, input logic [13:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        n = 0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) stall();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, idx, wd, d, e);
    endtask

    task automatic reset_values;
        logic [31:0] d;
        logic        e;
        apb(1'b0, afe_route_pkg::MODE_IDX, 8'h00, d, e);
        cmp(d, {24'h0, afe_route_pkg::MODE_RESET});
        apb(1'b0, afe_route_pkg::PREAMP_IDX, 8'h00, d, e);
        cmp(d, {24'h0, afe_route_pkg::PREAMP_RESET});
        apb(1'b0, afe_route_pkg::REMOTE_IDX, 8'h00, d, e);
        cmp(d, {24'h0, afe_route_pkg::REMOTE_RESET});
        apb(1'b0, 14'h2200, 8'h00, d, e);
        cmp({d[30:0], e}, 32'h1);
    endtask

    // Write, read back, wait for outputs to follow
    task automatic cfg(input logic [13:0] idx, input logic [7:0] wd,
                       input logic [7:0] exp);
        logic [31:0] d;
        logic        e;
        int          n;
        apb(1'b1, idx, wd, d, e);
        apb(1'b0, idx, 8'h00, d, e);
        cmp(d, {24'h0, wd});
        n = 0;
        while ({pdiff, gain8, rmt} !== exp && n < 100) begin
            @(posedge pclk);
            n++;
        end
        cmp({24'h0, pdiff, gain8, rmt}, {24'h0, exp});
    endtask

    task automatic config_bits;
        wr(afe_route_pkg::MUX_BASE_IDX, 8'h10);
        cfg(afe_route_pkg::MODE_IDX, 8'h10, 8'h10);
        cfg(afe_route_pkg::MODE_IDX, 8'hf0, 8'hf0);
        cfg(afe_route_pkg::MODE_IDX, 8'h0f, 8'h00);
        cfg(afe_route_pkg::PREAMP_IDX, 8'h20, 8'h08);
        cfg(afe_route_pkg::PREAMP_IDX, 8'hdf, 8'h00);
        cfg(afe_route_pkg::REMOTE_IDX, 8'h38, 8'h07);
        cfg(afe_route_pkg::REMOTE_IDX, 8'hc7, 8'h00);
        cfg(afe_route_pkg::REMOTE_IDX, 8'h10, 8'h02);
    endtask

    // Command the far side, look for the bypass write
    task automatic remote_go(input logic [2:0] ln, input logic [3:0] lg,
                             input logic st, input logic [4:0] ea,
                             input int en);
        int n;
        rem_q.delete();
        stray <= st;
        lag <= lg;
        value <= {8'h5a, 11'h0, ea};
        send <= ln;
        @(posedge pclk);
        send <= 3'h0;
        n = 0;
        while (n < 30 && rem_q.size() < en) begin
            @(posedge pclk);
            n++;
        end
        if (en == 0) repeat (30) @(posedge pclk);
        cmp(rem_q.size(), en);
        if (en > 0) cmp({rem_q[0].addr, rem_q[0].data}, {ea, value});
        stray <= 1'b0;
    endtask

    task automatic remote_paths;
        cfg(afe_route_pkg::REMOTE_IDX, 8'h08, 8'h01);
        remote_go(3'b001, 4'h0, 1'b0, 5'h11, 1);
        remote_go(3'b010, 4'h0, 1'b1, 5'h12, 0);
        cfg(afe_route_pkg::REMOTE_IDX, 8'h28, 8'h05);
        remote_go(3'b100, 4'h6, 1'b0, 5'h13, 1);
    endtask

    // Three-slot frame: select and RAM slot order
    task automatic frame_check(input logic [7:0] rb, input logic [3:0] s0,
                               input logic [3:0] s1, input logic [3:0] s2);
        int n;
        int hit;
        wr(afe_route_pkg::MUX_BASE_IDX, 8'h00);
        wr(afe_route_pkg::REMOTE_IDX, rb);
        wr(afe_route_pkg::MUX_BASE_IDX, 8'h30);
        wr(afe_route_pkg::MUX_BASE_IDX + 14'h5, {s1, s0});
        wr(afe_route_pkg::MUX_BASE_IDX + 14'h4, {4'h0, s2});
        sel_q.delete();
        loc_q.delete();
        n = 0;
        while (loc_q.size() < 12 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (n == 2000) stall();
        hit = 0;
        for (int i = 0; i + 3 < sel_q.size(); i++)
            if ({sel_q[i], sel_q[i+1], sel_q[i+2], sel_q[i+3]} ===
                {s0, s1, s2, s0}) hit = 1;
        cmp(hit, 1);
        hit = 0;
        for (int i = 0; i + 3 < loc_q.size(); i++)
            if ({loc_q[i].addr, loc_q[i+1].addr, loc_q[i+2].addr,
                 loc_q[i+3].addr} === 20'h00440 &&
                loc_q[i+1].data === 24'(FIR / 2)) hit = 1;
        cmp(hit, 1);
    endtask

    // Zero count: the frame in flight ends, then nothing more
    task automatic stop_check;
        wr(afe_route_pkg::MUX_BASE_IDX, 8'h00);
        repeat (60) @(posedge pclk);
        loc_q.delete();
        repeat (60) @(posedge pclk);
        cmp(loc_q.size(), 0);
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        mod_bit = 1'b0;
        stray = 1'b0;
        send = 3'h0;
        lag = 4'h0;
        value = 24'h0;
        sel_prev = 4'h0;
        err_total = 0;
        checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        config_bits();
        remote_paths();
        frame_check(8'h38, 4'h0, 4'h8, 4'ha);
        frame_check(8'h00, 4'h2, 4'h9, 4'h6);
        stop_check();
        close_out();
    end
endmodule
